// >>> verification/pulse_source.sv
// Behavioural external pulse source that drives one count or gate pin
`timescale 1ns/1ns
module pulse_source (
	input wire logic clock,
	input wire logic rstn,
	input wire logic enable,
	input wire logic [3:0] halfMc,
	output logic pin,
	output int falls
);
	logic [7:0] cnt;
	// Pin has a pull-up, so it rests high while the source is idle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin <= 1'b1;
			cnt <= 8'h00;
			falls <= 0;
		end else if (!enable && pin) begin
			cnt <= 8'h00;
		end else if (int'(cnt) == int'(halfMc) * 12 - 1) begin
			// A low half is always finished, so no pulse is shorter than a machine cycle
			// Half period never below one machine cycle keeps the rate at or under clock/24
			cnt <= 8'h00;
			pin <= !pin;
			if (pin && enable) begin
				falls <= falls + 1;
			end
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule // pulse_source

// >>> verification/three_timer_counter_unit_tb_top.sv
// Self-checking bench for the three timer/counter unit
`timescale 1ns/1ns
module three_timer_counter_unit_tb_top import timer_unit_pkg::*;;
	logic clock, rstn, g0, g1, trig, en0, en1, en2;
	axiReq_t axiReq;
	axiRsp_t axiRsp;
	logic [3:0] ccIn, ccOut, ccOeN;
	logic p0, p1, p2;
	int f0, f1, f2, err_total, n_checks, tDone, n, fb, sv;
	int cyc = 0;
	logic [31:0] rd, v;
	logic [1:0] rs;

	three_timer_counter_unit three_timer_counter_unit_inst (.clock(clock), .rstn(rstn), .axiReq(axiReq),
		.axiRsp(axiRsp), .tmr0CountPin(p0), .tmr1CountPin(p1), .extIrq0GatePin(g0), .extIrq1GatePin(g1),
		.tmr2CountGatePin(p2), .tmr2ReloadTriggerPin(trig), .capcmpPinIn(ccIn), .capcmpPinOut(ccOut),
		.capcmpPinOeN(ccOeN));
	pulse_source src0 (.clock(clock), .rstn(rstn), .enable(en0), .halfMc(4'h1), .pin(p0), .falls(f0));
	pulse_source src1 (.clock(clock), .rstn(rstn), .enable(en1), .halfMc(4'h2), .pin(p1), .falls(f1));
	pulse_source src2 (.clock(clock), .rstn(rstn), .enable(en2), .halfMc(4'h3), .pin(p2), .falls(f2));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic finish_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard well above the whole run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// Bus timing makes the elapsed machine cycles uncertain by one
	task automatic chk3(input string nm, input logic [31:0] e0, e1, e2, g);
		chk(nm, (g === e0 || g === e2) ? g : e1, g);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clock);
		axiReq.awaddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= s;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		while (aw || w) begin
			@(posedge clock);
			if (aw && axiRsp.awready === 1'b1) begin
				aw = 1'b0;
				axiReq.awvalid <= 1'b0;
			end
			if (w && axiRsp.wready === 1'b1) begin
				w = 1'b0;
				axiReq.wvalid <= 1'b0;
			end
		end
		while (axiRsp.bvalid !== 1'b1) @(posedge clock);
		rs = axiRsp.bresp;
		axiReq.bready <= 1'b0;
		tDone = cyc;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do @(posedge clock); while (axiRsp.arready !== 1'b1);
		axiReq.arvalid <= 1'b0;
		while (axiRsp.rvalid !== 1'b1) @(posedge clock);
		rd = axiRsp.rdata;
		rs = axiRsp.rresp;
		axiReq.rready <= 1'b0;
	endtask

	task automatic mc(input int k);
		repeat (k * 12) @(posedge clock);
	endtask

	// Reference count of timer 0/1 after k machine cycles
	function automatic logic [31:0] t01(input int m, input logic [15:0] s, input int k);
		logic [12:0] c;
		int lo;
		c = {s[15:8], s[4:0]} + 13'(k);
		lo = int'(s[7:0]) + k;
		case (m)
			0: return {16'h0000, c[12:5], 3'h0, c[4:0]};
			1: return {16'h0000, s + 16'(k)};
			2: return (lo < 256) ? {16'h0000, s[15:8], 8'(lo)} :
				{16'h0000, s[15:8], 8'(int'(s[15:8]) + (lo - 256) % (256 - int'(s[15:8])))};
			default: return {16'h0000, 8'(k), 8'(k)};
		endcase
	endfunction

	initial begin
		axiReq = '0;
		{rstn, g0, g1, en0, en1, en2} = 6'h00;
		trig = 1'b1;
		ccIn = 4'h0;
		sv = $urandom(43);
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		chk("oen reset", 32'hF, ccOeN);
		rdr(OFF_T0CNT);
		chk("t0 reset", 0, rd);
		rdr(8'h2C);
		chk("unmapped rresp", RESP_SLVERR, rs);
		chk("unmapped rdata", 0, rd);
		wr(8'h02, 32'h1, 4'hF);
		chk("unaligned bresp", RESP_SLVERR, rs);
		for (int m = 0; m < 3; m++) begin
			sv = (m == 2) ? 32'hF0FE : 0;
			wr(OFF_T0CNT, sv, 4'hF);
			wr(OFF_TCTRL, 32'h100 | m, 4'hF);
			fb = tDone;
			mc(m == 0 ? 70 : 20);
			wr(OFF_TCTRL, m, 4'hF);
			n = (tDone - fb) / 12;
			rdr(OFF_T0CNT);
			chk3("t0 mode", t01(m, sv, n - 1), t01(m, sv, n), t01(m, sv, n + 1), rd & (m ? 32'hFFFF : 32'hFF1F));
		end
		sv = $urandom & 32'hFFFF;
		wr(OFF_T1CNT, sv, 4'hF);
		wr(OFF_T0CNT, 0, 4'hF);
		wr(OFF_TCTRL, 32'h333, 4'hF);
		fb = tDone;
		mc(20);
		wr(OFF_TCTRL, 32'h33, 4'hF);
		n = (tDone - fb) / 12;
		rdr(OFF_T0CNT);
		chk3("t0 split", t01(3, 0, n - 1), t01(3, 0, n), t01(3, 0, n + 1), rd);
		rdr(OFF_T1CNT);
		chk("t1 frozen", sv, rd);
		wr(OFF_T0CNT, 0, 4'hF);
		wr(OFF_TCTRL, 32'h105, 4'hF);
		en0 <= 1'b1;
		mc(30);
		en0 <= 1'b0;
		mc(5);
		rdr(OFF_T0CNT);
		chk("t0 pulses", f0, rd);
		wr(OFF_T1CNT, 0, 4'hF);
		wr(OFF_TCTRL, 32'h2D0, 4'hF);
		for (int gl = 0; gl < 2; gl++) begin
			g1 <= gl[0];
			fb = f1;
			en1 <= 1'b1;
			mc(20);
			en1 <= 1'b0;
			mc(5);
			rdr(OFF_T1CNT);
			chk("t1 gated", gl ? f1 - fb : 0, rd);
		end
		wr(OFF_T0CNT, 0, 4'hF);
		wr(OFF_TCTRL, 32'h109, 4'hF);
		mc(10);
		rdr(OFF_T0CNT);
		chk("t0 gate closed", 0, rd);
		wr(OFF_T2CNT, 0, 4'hF);
		wr(OFF_T2CTRL, 32'h5, 4'hF);
		fb = tDone;
		mc(40);
		wr(OFF_T2CTRL, 0, 4'hF);
		n = (tDone - fb) / 12;
		rdr(OFF_T2CNT);
		chk3("t2 prescale", (n - 2) / 2, n / 2, (n + 2) / 2, rd);
		wr(OFF_T2CNT, 0, 4'hF);
		wr(OFF_T2CTRL, 32'h2, 4'hF);
		fb = f2;
		en2 <= 1'b1;
		mc(24);
		en2 <= 1'b0;
		mc(5);
		rdr(OFF_T2CNT);
		chk("t2 pulses", f2 - fb, rd);
		wr(OFF_CC0, 32'hFFF0, 4'hF);
		wr(OFF_T2CNT, 32'hFFF0, 4'hF);
		wr(8'h20, 32'hFFF8, 4'hF);
		wr(OFF_CCEN, 32'h8, 4'hF);
		wr(OFF_STAT, 32'hFF, 4'h1);
		wr(OFF_T2CTRL, 32'h9, 4'hF);
		mc(37);
		wr(OFF_T2CTRL, 32'h8, 4'hF);
		rdr(OFF_T2CNT);
		v = rd;
		chk("t2 reload range", 32'hFFF, v[31:4]);
		chk("compare0 out", v[15:0] >= 16'hFFF8, ccOut[1]);
		chk("compare oen", 0, ccOeN[1]);
		rdr(OFF_STAT);
		chk("tf2 and match flag", 2'h3, {rd[ST_TF2], rd[ST_CCF + 1]});
		for (int lv = 1; lv >= 0; lv--) begin
			wr(OFF_CCEN, 32'h1008 | (lv << 9), 4'hF);
			wr(OFF_T2CTRL, 32'h9, 4'hF);
			mc(20);
			wr(OFF_T2CTRL, 32'h8, 4'hF);
			chk("compare1 out", lv, ccOut[1]);
		end
		sv = $urandom & 32'hFFFF;
		wr(OFF_T2CNT, sv, 4'hF);
		wr(OFF_CCEN, 32'h70, 4'hF);
		ccIn <= 4'h8;
		mc(1);
		rdr(8'h28);
		chk("pin capture", sv, rd);
		wr(8'h24, 32'h0, 4'h1);
		rdr(8'h24);
		chk("write capture", sv, rd);
		wr(OFF_CC0, 32'hABCD, 4'hF);
		wr(OFF_T2CNT, 32'h5, 4'hF);
		wr(OFF_STAT, 32'hFF, 4'h1);
		wr(OFF_T2CTRL, 32'h38, 4'hF);
		trig <= 1'b0;
		mc(3);
		rdr(OFF_T2CNT);
		chk("trigger reload", 32'hABCD, rd);
		rdr(OFF_STAT);
		chk("trigger flag", 1, rd[ST_EXF2]);
		trig <= 1'b1;
		finish_test();
	end
endmodule // three_timer_counter_unit_tb_top

// >>> verilog/three_timer_counter_unit.sv
// Three timer/counters with capture/compare unit behind an AXI4-Lite register slave
`timescale 1ns/1ns
module three_timer_counter_unit import timer_unit_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire axiReq_t axiReq,
	output axiRsp_t axiRsp,
	input wire logic tmr0CountPin,
	input wire logic tmr1CountPin,
	input wire logic extIrq0GatePin,
	input wire logic extIrq1GatePin,
	input wire logic tmr2CountGatePin,
	input wire logic tmr2ReloadTriggerPin,
	input wire logic [3:0] capcmpPinIn,
	output logic [3:0] capcmpPinOut,
	output logic [3:0] capcmpPinOeN
);
	// Bus and configuration state
	logic awRdy_q, awRdy_d, bValid_q, bValid_d, arRdy_q, arRdy_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d;
	logic [TCTRL_W-1:0] tCtrl_q, tCtrl_d;
	logic [T2CTRL_W-1:0] t2Ctrl_q, t2Ctrl_d;
	logic [CCEN_W-1:0] ccEn_q, ccEn_d;
	logic [STAT_W-1:0] stat_q, stat_d;
	// Timer state
	logic [3:0] mcCnt_q, mcCnt_d;
	logic [3:0] smp_q, smp_d;
	logic [15:0] t0_q, t0_d, t1_q, t1_d, t2_q, t2_d;
	logic preTgl_q, preTgl_d;
	logic [15:0] cc_q [4];
	logic [15:0] cc_d [4];
	logic [3:0] capPrev_q, capPrev_d, matchPrev_q, matchPrev_d;
	logic [3:0] pinOut_q, pinOut_d, pinOeN_q, pinOeN_d;

	logic wrFire, rdFire, mcTick;
	logic [ADDR_W-1:0] wrOff, rdOff;
	logic [3:0] fall;
	logic tf0Set, tf1Set, tf2Set, exf2Set, ovf2, extEdge, t2Inc, inc0, inc1;
	logic [3:0] ccHit, ccCap, ccEvt;
	t01Mode_t mode0, mode1;
	ccMode_t [3:0] ccMode;

	assign wrFire = awRdy_q & axiReq.awvalid & axiReq.wvalid;
	assign rdFire = arRdy_q & axiReq.arvalid;
	assign wrOff = axiReq.awaddr;
	assign rdOff = axiReq.araddr;
	assign mcTick = (mcCnt_q == MC_LAST);
	assign mode0 = t01Mode_t'(tCtrl_q[TC_MODE0+:2]);
	assign mode1 = t01Mode_t'(tCtrl_q[TC_MODE1+:2]);
	// Falling transition between two machine-cycle samples; caps the rate at osc/24
	assign fall = {4{mcTick}} & smp_q & ~{tmr2ReloadTriggerPin, tmr2CountGatePin, tmr1CountPin, tmr0CountPin};
	for (genvar g = 0; g < 4; g++) begin : g_mode
		assign ccMode[g] = ccMode_t'(ccEn_q[2*g+:2]);
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b+:8] = data[8*b+:8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a <= OFF_LAST);
	endfunction

	// Next count of timer 0/1 in modes 0..2, low byte only in split mode; bit 16 is overflow
	function automatic logic [16:0] step01(input t01Mode_t m, input logic [15:0] c, input logic inc);
		logic [16:0] r;
		r = {1'b0, c};
		if (inc) begin
			case (m)
				T01_PRESCALE13: begin
					r[4:0] = c[4:0] + 5'h01;
					if (c[4:0] == 5'h1F) begin
						r[15:8] = c[15:8] + 8'h01;
						r[16] = (c[15:8] == 8'hFF);
					end
				end
				T01_COUNT16: r = {c == 16'hFFFF, c + 16'h0001};
				T01_RELOAD8: begin
					r[7:0] = (c[7:0] == 8'hFF) ? c[15:8] : c[7:0] + 8'h01;
					r[16] = (c[7:0] == 8'hFF);
				end
				T01_SPLIT: begin
					r[7:0] = c[7:0] + 8'h01;
					r[16] = (c[7:0] == 8'hFF);
				end
				default: r = {1'b0, c};
			endcase
		end
		return r;
	endfunction

	function automatic logic [31:0] readValue(input logic [ADDR_W-1:0] a, input logic [TCTRL_W-1:0] tc,
			input logic [STAT_W-1:0] st, input logic [15:0] c0, input logic [15:0] c1,
			input logic [T2CTRL_W-1:0] t2c, input logic [15:0] c2, input logic [CCEN_W-1:0] ce);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFF_TCTRL: r[TCTRL_W-1:0] = tc;
			OFF_STAT: r[STAT_W-1:0] = st;
			OFF_T0CNT: r[15:0] = c0;
			OFF_T1CNT: r[15:0] = c1;
			OFF_T2CTRL: r[T2CTRL_W-1:0] = t2c;
			OFF_T2CNT: r[15:0] = c2;
			OFF_CCEN: r[CCEN_W-1:0] = ce;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Register bus and configuration
	always_comb begin
		awRdy_d = 1'b0;
		arRdy_d = 1'b0;
		bValid_d = bValid_q & ~axiReq.bready;
		rValid_d = rValid_q & ~axiReq.rready;
		bResp_d = bResp_q;
		rResp_d = rResp_q;
		rData_d = rData_q;
		tCtrl_d = tCtrl_q;
		t2Ctrl_d = t2Ctrl_q;
		ccEn_d = ccEn_q;
		// One write and one read in flight; write ready pulses only once both address and data are offered
		if (!awRdy_q && !bValid_q && axiReq.awvalid && axiReq.wvalid) begin
			awRdy_d = 1'b1;
		end
		if (!arRdy_q && !rValid_q && axiReq.arvalid) begin
			arRdy_d = 1'b1;
		end
		if (wrFire) begin
			bValid_d = 1'b1;
			bResp_d = mapped(wrOff) ? RESP_OKAY : RESP_SLVERR;
			case (wrOff)
				OFF_TCTRL: tCtrl_d = TCTRL_W'(merge(32'(tCtrl_q), axiReq.wdata, axiReq.wstrb));
				OFF_T2CTRL: t2Ctrl_d = T2CTRL_W'(merge(32'(t2Ctrl_q), axiReq.wdata, axiReq.wstrb));
				OFF_CCEN: ccEn_d = CCEN_W'(merge(32'(ccEn_q), axiReq.wdata, axiReq.wstrb));
				default: ;
			endcase
		end
		if (rdFire) begin
			rValid_d = 1'b1;
			rResp_d = mapped(rdOff) ? RESP_OKAY : RESP_SLVERR;
			rData_d = readValue(rdOff, tCtrl_q, stat_q, t0_q, t1_q, t2Ctrl_q, t2_q, ccEn_q);
			if (rdOff >= OFF_CC0 && mapped(rdOff)) begin
				rData_d = {16'h0000, cc_q[rdOff[3:2] - 2'h3]};
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			awRdy_q <= 1'b0;
			arRdy_q <= 1'b0;
			bValid_q <= 1'b0;
			rValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			rResp_q <= RESP_OKAY;
			rData_q <= 32'h0000_0000;
			tCtrl_q <= '0;
			t2Ctrl_q <= '0;
			ccEn_q <= '0;
		end else begin
			awRdy_q <= awRdy_d;
			arRdy_q <= arRdy_d;
			bValid_q <= bValid_d;
			rValid_q <= rValid_d;
			bResp_q <= bResp_d;
			rResp_q <= rResp_d;
			rData_q <= rData_d;
			tCtrl_q <= tCtrl_d;
			t2Ctrl_q <= t2Ctrl_d;
			ccEn_q <= ccEn_d;
		end
	end

	assign axiRsp = '{awready: awRdy_q, wready: awRdy_q, bresp: bResp_q, bvalid: bValid_q,
		arready: arRdy_q, rdata: rData_q, rresp: rResp_q, rvalid: rValid_q};

	// Timers 0 and 1, machine-cycle base and input sampling
	always_comb begin
		logic [16:0] r0, r1;
		logic hiInc;
		r0 = '0;
		r1 = '0;
		hiInc = 1'b0;
		mcCnt_d = mcTick ? 4'h0 : mcCnt_q + 4'h1;
		smp_d = smp_q;
		if (mcTick) begin
			smp_d = {tmr2ReloadTriggerPin, tmr2CountGatePin, tmr1CountPin, tmr0CountPin};
		end
		// Gate pin only qualifies the count while gating is programmed
		inc0 = tCtrl_q[TC_RUN0] & (~tCtrl_q[TC_GATE0] | extIrq0GatePin) & (tCtrl_q[TC_CT0] ? fall[0] : mcTick);
		inc1 = tCtrl_q[TC_RUN1] & (~tCtrl_q[TC_GATE1] | extIrq1GatePin) & (tCtrl_q[TC_CT1] ? fall[1] : mcTick);
		r0 = step01(mode0, t0_q, inc0);
		// A timer 1 left in split mode freezes
		r1 = step01(mode1, t1_q, (mode1 == T01_SPLIT) ? 1'b0 : inc1);
		t0_d = r0[15:0];
		t1_d = r1[15:0];
		tf0Set = r0[16];
		tf1Set = r1[16];
		if (mode0 == T01_SPLIT) begin
			hiInc = tCtrl_q[TC_RUN1] & mcTick;
			t0_d[15:8] = t0_q[15:8] + {7'h00, hiInc};
			tf1Set = hiInc & (t0_q[15:8] == 8'hFF);
		end
		if (wrFire && wrOff == OFF_T0CNT) begin
			t0_d = 16'(merge({16'h0000, t0_q}, axiReq.wdata, axiReq.wstrb));
		end
		if (wrFire && wrOff == OFF_T1CNT) begin
			t1_d = 16'(merge({16'h0000, t1_q}, axiReq.wdata, axiReq.wstrb));
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mcCnt_q <= 4'h0;
			smp_q <= 4'h0;
			t0_q <= RST_COUNT;
			t1_q <= RST_COUNT;
		end else begin
			mcCnt_q <= mcCnt_d;
			smp_q <= smp_d;
			t0_q <= t0_d;
			t1_q <= t1_d;
		end
	end

	// Timer 2 with reload, capture and compare channels; channel 0 doubles as reload value
	always_comb begin
		logic src;
		logic [31:0] stClr;
		src = 1'b0;
		stClr = '0;
		case (t2Src_t'(t2Ctrl_q[T2C_SEL+:2]))
			T2_TIMER: src = mcTick;
			T2_COUNT_PIN: src = fall[2];
			T2_GATED_TIMER: src = mcTick & tmr2CountGatePin;
			default: src = 1'b0;
		endcase
		preTgl_d = preTgl_q ^ (src & t2Ctrl_q[T2C_PRE]);
		t2Inc = src & (~t2Ctrl_q[T2C_PRE] | preTgl_q);
		ovf2 = t2Inc & (t2_q == 16'hFFFF);
		extEdge = fall[3];
		t2_d = t2Inc ? t2_q + 16'h0001 : t2_q;
		if (ovf2 && t2Ctrl_q[T2C_RLEN] && !t2Ctrl_q[T2C_RLMODE]) begin
			t2_d = cc_q[0];
		end
		if (extEdge && t2Ctrl_q[T2C_RLEN] && t2Ctrl_q[T2C_RLMODE]) begin
			t2_d = cc_q[0];
		end
		if (wrFire && wrOff == OFF_T2CNT) begin
			t2_d = 16'(merge({16'h0000, t2_q}, axiReq.wdata, axiReq.wstrb));
		end
		tf2Set = ovf2;
		exf2Set = extEdge & t2Ctrl_q[T2C_EXEN];
		capPrev_d = capcmpPinIn;
		matchPrev_d = matchPrev_q;
		pinOut_d = pinOut_q;
		pinOeN_d = pinOeN_q;
		for (int i = 0; i < 4; i++) begin
			cc_d[i] = cc_q[i];
			ccHit[i] = 1'b0;
			ccCap[i] = 1'b0;
			matchPrev_d[i] = (t2_q == cc_q[i]);
			pinOeN_d[i] = (ccMode[i] != CC_COMPARE);
			if (wrFire && wrOff == OFF_CC0 + 8'(4 * i)) begin
				cc_d[i] = 16'(merge({16'h0000, cc_q[i]}, axiReq.wdata, axiReq.wstrb));
				if (ccMode[i] == CC_CAPTURE_WRITE && axiReq.wstrb[0]) begin
					cc_d[i] = t2_q;
					ccCap[i] = 1'b1;
				end
			end
			// Rising transition on the pin; pins are already synchronous
			if (ccMode[i] == CC_CAPTURE_PIN && capcmpPinIn[i] && !capPrev_q[i]) begin
				cc_d[i] = t2_q;
				ccCap[i] = 1'b1;
			end
			// Only the first cycle of equality counts, so a stopped timer does not retrigger
			if (ccMode[i] == CC_COMPARE && t2_q == cc_q[i] && !matchPrev_q[i]) begin
				ccHit[i] = 1'b1;
			end
			if (!ccEn_q[CCEN_CMPMODE]) begin
				if (ovf2) begin
					pinOut_d[i] = 1'b0;
				end
				if (ccHit[i]) begin
					pinOut_d[i] = 1'b1;
				end
			end else if (ccHit[i]) begin
				pinOut_d[i] = ccEn_q[CCEN_LEVEL + i];
			end
		end
		ccEvt = ccHit | ccCap;
		// Hardware set wins over a same-cycle write-one-to-clear
		if (wrFire && wrOff == OFF_STAT) begin
			stClr = axiReq.wdata & {{24{1'b0}}, {8{axiReq.wstrb[0]}}};
		end
		stat_d = (stat_q & ~stClr[STAT_W-1:0]) | {ccEvt, exf2Set, tf2Set, tf1Set, tf0Set};
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			t2_q <= RST_COUNT;
			preTgl_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cc_q[i] <= RST_COUNT;
			end
			capPrev_q <= 4'h0;
			matchPrev_q <= 4'h0;
			pinOut_q <= 4'h0;
			pinOeN_q <= 4'hF;
			stat_q <= '0;
		end else begin
			t2_q <= t2_d;
			preTgl_q <= preTgl_d;
			for (int i = 0; i < 4; i++) begin
				cc_q[i] <= cc_d[i];
			end
			capPrev_q <= capPrev_d;
			matchPrev_q <= matchPrev_d;
			pinOut_q <= pinOut_d;
			pinOeN_q <= pinOeN_d;
			stat_q <= stat_d;
		end
	end

	assign capcmpPinOut = pinOut_q;
	assign capcmpPinOeN = pinOeN_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	mcTick_period_a: assert property (mcTick |-> ##12 mcTick) else $error("machine cycle not 12 clocks");
	t16_step_a: assert property (mode0 == T01_COUNT16 && inc0 && t0_q != 16'hFFFF && !wrFire
		|=> t0_q == $past(t0_q) + 16'h0001) else $error("timer 0 16-bit step wrong");
	t13_carry_a: assert property (mode0 == T01_PRESCALE13 && inc0 && t0_q[4:0] == 5'h1F && !wrFire
		|=> t0_q[15:8] == $past(t0_q[15:8]) + 8'h01) else $error("prescaler carry lost");
	reload8_a: assert property (mode0 == T01_RELOAD8 && inc0 && t0_q[7:0] == 8'hFF && !wrFire
		|=> t0_q[7:0] == $past(t0_q[15:8]) && stat_q[ST_TF0]) else $error("8-bit reload wrong");
	t1_frozen_a: assert property (mode1 == T01_SPLIT && !(wrFire && wrOff == OFF_T1CNT)
		|=> $stable(t1_q)) else $error("timer 1 moved in split mode");
	gate_block_a: assert property (tCtrl_q[TC_GATE0] && !extIrq0GatePin && mode0 != T01_SPLIT && !wrFire
		|=> $stable(t0_q)) else $error("gated timer 0 counted");
	pin_count_a: assert property (tCtrl_q[TC_CT0] && tCtrl_q[TC_RUN0] && !tCtrl_q[TC_GATE0] && !mcTick
		&& mode0 != T01_SPLIT && !wrFire |=> $stable(t0_q)) else $error("count between samples");
	ovf_reload_a: assert property (ovf2 && t2Ctrl_q[T2C_RLEN] && !t2Ctrl_q[T2C_RLMODE] && !wrFire
		|=> t2_q == $past(cc_q[0]) && stat_q[ST_TF2]) else $error("overflow reload wrong");
	ext_reload_a: assert property (extEdge && t2Ctrl_q[T2C_RLEN] && t2Ctrl_q[T2C_RLMODE] && !wrFire
		|=> t2_q == $past(cc_q[0])) else $error("trigger reload missing");
	pin_capture_a: assert property (ccMode[3] == CC_CAPTURE_PIN && $rose(capcmpPinIn[3]) && !wrFire
		|=> cc_q[3] == $past(t2_q) && stat_q[ST_CCF + 3]) else $error("pin capture wrong");
	cmp_high_a: assert property (!ccEn_q[CCEN_CMPMODE] && ccHit[1] |=> capcmpPinOut[1] && !capcmpPinOeN[1]
		&& stat_q[ST_CCF + 1]) else $error("compare mode 0 output not high");
	cmp_keep_a: assert property (ccEn_q[CCEN_CMPMODE] && ovf2 && ccHit == 4'h0
		|=> $stable(capcmpPinOut)) else $error("overflow changed mode 1 output");

	reload_seen_c: cover property (ovf2 && t2Ctrl_q[T2C_RLEN]);
	capture_seen_c: cover property (ccCap[0] ##[1:50] ccCap[0]);
	compare_cycle_c: cover property (ccHit[3] ##[1:1000] ovf2);
	split_seen_c: cover property (mode0 == T01_SPLIT && tf1Set);
endmodule // three_timer_counter_unit

// >>> verilog/timer_unit_pkg.sv
// Package: bus carriers, register map, field layout and modes of the timer/counter unit
// What this block does
// - Timers tick at oscillator over twelve
// - Count external pulses, source below oscillator/24
// - Timers 0/1 mode 0: 8-bit, 32:1 prescaler
// - Timers 0/1 mode 1: full 16-bit count
// - Mode 2: 8-bit count, auto-reload from high
// - Mode 3: timer 0 splits, timer 1 holds
// - Gate lets pin enable timer 0/1 counting
// - Timer 2 16-bit, 2:1 prescaler, selectable gate
// - Four capture/compare registers; channel 0 reloads
// - Reload mode 0: overflow loads channel 0 value
// - Reload mode 1: trigger falling edge reloads, flags
// - Capture mode 0: pin rising edge latches timer 2
// - Capture mode 1: low-byte write latches timer 2
// - Compare match acts on output, sets its status flag
// - Compare mode 0: match high, overflow low
// - Compare mode 1: software level, overflow ignored
// - Timer 2 count and gate share one pin
// - Timer 0/1 count inputs are own pins
// - Channel pins capture input and compare output
package timer_unit_pkg;
	localparam int ADDR_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} axiReq_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axiRsp_t;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [ADDR_W-1:0] OFF_TCTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_T0CNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_T1CNT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_T2CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_T2CNT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CCEN = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CC0 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_LAST = 8'h28;

	// Oscillator clocks per machine cycle
	localparam int MC_DIVIDE = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_DIVIDE - 1);

	localparam int TC_MODE0 = 0;
	localparam int TC_CT0 = 2;
	localparam int TC_GATE0 = 3;
	localparam int TC_MODE1 = 4;
	localparam int TC_CT1 = 6;
	localparam int TC_GATE1 = 7;
	localparam int TC_RUN0 = 8;
	localparam int TC_RUN1 = 9;
	localparam int TCTRL_W = 10;

	localparam int T2C_SEL = 0;
	localparam int T2C_PRE = 2;
	localparam int T2C_RLEN = 3;
	localparam int T2C_RLMODE = 4;
	localparam int T2C_EXEN = 5;
	localparam int T2CTRL_W = 6;

	localparam int CCEN_LEVEL = 8;
	localparam int CCEN_CMPMODE = 12;
	localparam int CCEN_W = 13;

	localparam int ST_TF0 = 0;
	localparam int ST_TF1 = 1;
	localparam int ST_TF2 = 2;
	localparam int ST_EXF2 = 3;
	localparam int ST_CCF = 4;
	localparam int STAT_W = 8;

	localparam logic [15:0] RST_COUNT = 16'h0000;

	typedef enum logic [1:0] {T01_PRESCALE13, T01_COUNT16, T01_RELOAD8, T01_SPLIT} t01Mode_t;
	typedef enum logic [1:0] {T2_STOP, T2_TIMER, T2_COUNT_PIN, T2_GATED_TIMER} t2Src_t;
	typedef enum logic [1:0] {CC_OFF, CC_CAPTURE_PIN, CC_COMPARE, CC_CAPTURE_WRITE} ccMode_t;
endpackage
